/* logic/sar_device.sv */
// Device end: serial slave holding the converter state and result.
`timescale 1ns/1ps
`include "sar_regs.svh"
module sar_device (
    input  wire logic              clk,
    input  wire logic              rstn,
    sar_link_if.device             link,
    input  wire sar_pkg::sar_result_t sample_in,
    output logic                   conv_start,
    output logic                   input_select,
    output logic                   converter_enable
);
    import sar_pkg::*;

    // Conversion time counter wide enough for the least conversion time.
    localparam int CW = $clog2(`SAR_CONV_CYCLES + 1);

    logic [2:0]    sclk_s_q, sel_s_q;
    logic [1:0]    mosi_s_q;
    logic          sclk_rise, sclk_fall, sel_act;
    logic [4:0]    bit_cnt_q;
    sar_op_t       op_q;
    sar_word_t     ans_q;
    logic          miso_q, oe_n_q;
    logic          done_q, input_select_q, en_q;
    logic [CW-1:0] conv_cnt_q;
    logic [7:0]    init_cnt_q;
    sar_result_t   result_q;
    sar_op_t       op_full;
    logic          start_req;

    // Clock and select are sampled three times, data twice; only the later stages feed logic.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclk_s_q <= 3'h0;
            sel_s_q  <= 3'h7;
            mosi_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            sel_s_q  <= {sel_s_q[1:0], link.sel_n};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
        end
    end

    assign sclk_rise   = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall   = ~sclk_s_q[1] & sclk_s_q[2];
    assign sel_act     = ~sel_s_q[1];
    assign op_full     = {op_q[6:0], mosi_s_q[1]};

    function automatic sar_cmd_e decode(input sar_op_t op);
        if (op == `SAR_OP_RESULT_READ) begin
            decode = SAR_CMD_RESULT;
        end else if (op == `SAR_OP_STATUS_READ) begin
            decode = SAR_CMD_STATUS;
        end else begin
            decode = SAR_CMD_CONVERT;
        end
    endfunction

    function automatic logic known_op(input sar_op_t op);
        known_op = (op == `SAR_OP_RESULT_READ) ||
                   (op == `SAR_OP_STATUS_READ) ||
                   ((op & `SAR_OP_CONV_MASK) == `SAR_OP_CONV_CTRL);
    endfunction

    // Opcode capture and bit counting, most significant bit first.
    always_ff @(posedge clk) begin
        if (!rstn || !sel_act) begin
            bit_cnt_q <= 5'h00;
            op_q      <= 8'h00;
        end else if (sclk_rise && bit_cnt_q != `SAR_FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q < `SAR_OP_BITS) begin
                op_q <= op_full;
            end
        end
    end

    // The opcode is complete on the eighth rising edge of the frame.
    logic op_done;
    assign op_done = sel_act && sclk_rise &&
                     bit_cnt_q == (`SAR_OP_BITS - 5'h01);
    assign start_req = op_done && known_op(op_full) &&
                       decode(op_full) == SAR_CMD_CONVERT &&
                       init_cnt_q == 8'h00 && done_q;

    // Answer word, built once the opcode is complete.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ans_q <= 16'h0000;
        end else if (op_done) begin
            ans_q <= 16'h0000;
            if (init_cnt_q != 8'h00 || !known_op(op_full) ||
                (decode(op_full) == SAR_CMD_CONVERT && !done_q)) begin
                ans_q[`SAR_ANS_REFUSE_BIT] <= 1'b1;
                ans_q[`SAR_ANS_OPC_BIT]    <= ~known_op(op_full);
                ans_q[`SAR_ANS_DONE_BIT]   <= done_q;
                ans_q[`SAR_ANS_BUSY_BIT]   <= init_cnt_q != 8'h00;
            end else if (decode(op_full) == SAR_CMD_RESULT) begin
                ans_q[`SAR_ANS_DONE_BIT] <= done_q;
                ans_q[`SAR_ANS_RES_HI:`SAR_ANS_RES_LO] <= result_q;
            end else begin
                // A start answers with done low, as the conversion runs.
                ans_q[`SAR_ANS_DONE_BIT] <=
                    done_q && decode(op_full) == SAR_CMD_STATUS;
                ans_q[`SAR_ANS_SEL_BIT] <=
                    decode(op_full) == SAR_CMD_STATUS ? input_select_q :
                    op_full[`SAR_CONV_SEL_BIT];
                ans_q[`SAR_ANS_EN_BIT] <=
                    decode(op_full) == SAR_CMD_STATUS ? en_q :
                    op_full[`SAR_CONV_EN_BIT];
            end
        end else if (sel_act && sclk_fall && bit_cnt_q >= `SAR_OP_BITS) begin
            ans_q <= {ans_q[14:0], 1'b0};
        end
    end

    // The answer bit is presented on each falling edge after the opcode.
    always_ff @(posedge clk) begin
        if (!rstn || !sel_act) begin
            miso_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (sclk_fall && bit_cnt_q >= `SAR_OP_BITS &&
                     bit_cnt_q < `SAR_FRAME_BITS) begin
            miso_q <= ans_q[15];
            oe_n_q <= 1'b0;
        end
    end

    // Converter mode bits; both clear at reset.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            input_select_q <= 1'b0;
            en_q   <= 1'b0;
        end else if (start_req) begin
            input_select_q <= op_full[`SAR_CONV_SEL_BIT];
            en_q   <= op_full[`SAR_CONV_EN_BIT];
        end
    end

    // Conversion timing, start strobe and held result.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            done_q     <= 1'b1;
            conv_cnt_q <= '0;
            result_q   <= 11'h000;
            conv_start <= 1'b0;
            init_cnt_q <= `SAR_INIT_CYCLES;
        end else begin
            conv_start <= 1'b0;
            if (init_cnt_q != 8'h00) begin
                init_cnt_q <= init_cnt_q - 8'h01;
            end
            if (start_req && op_full[`SAR_CONV_EN_BIT]) begin
                done_q     <= 1'b0;
                conv_cnt_q <= CW'(`SAR_CONV_CYCLES);
                conv_start <= 1'b1;
            end else if (!done_q) begin
                if (conv_cnt_q == CW'(1)) begin
                    done_q   <= 1'b1;
                    result_q <= sample_in;
                end
                conv_cnt_q <= conv_cnt_q - CW'(1);
            end
        end
    end

    assign link.miso_o      = miso_q;
    assign link.miso_oe_n   = oe_n_q;
    assign input_select     = input_select_q;
    assign converter_enable = en_q;
endmodule

/* logic/sar_host.sv */
// Host end: serial master issuing one command frame per request.
`timescale 1ns/1ps
`include "sar_regs.svh"
module sar_host (
    input  wire logic              clk,
    input  wire logic              rstn,
    sar_link_if.host               link,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire sar_pkg::sar_op_t  req_op,
    output logic                   rsp_valid,
    output sar_pkg::sar_word_t     rsp_word,
    output logic                   rsp_accepted,
    output logic                   rsp_done,
    output sar_pkg::sar_result_t   rsp_result
);
    import sar_pkg::*;

    typedef enum logic [1:0] {
        SAR_H_IDLE  = 2'b00,
        SAR_H_SHIFT = 2'b01,
        SAR_H_GAP   = 2'b10
    } sar_hstate_e;

    sar_hstate_e   st_q;
    logic [2:0]    div_q;
    logic [4:0]    bits_q;
    logic          sclk_q, sel_n_q;
    logic [23:0]   tx_q;
    sar_word_t     rx_q;
    logic [1:0]    miso_s_q;

    assign req_ready = (st_q == SAR_H_IDLE);

    // The answer pin is retimed before the shift register sees it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            miso_s_q <= 2'h0;
        end else begin
            miso_s_q <= {miso_s_q[0], link.miso_o};
        end
    end

    // Frame sequencer; the link clock is a divided copy of clk.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q    <= SAR_H_IDLE;
            div_q   <= 3'h0;
            bits_q  <= 5'h00;
            sclk_q  <= 1'b0;
            sel_n_q <= 1'b1;
            tx_q    <= 24'h000000;
            rx_q    <= 16'h0000;
        end else begin
            unique case (st_q)
                SAR_H_IDLE: begin
                    if (req_valid) begin
                        tx_q    <= {req_op, 16'h0000};
                        sel_n_q <= 1'b0;
                        div_q   <= 3'h0;
                        bits_q  <= 5'h00;
                        st_q    <= SAR_H_SHIFT;
                    end
                end
                SAR_H_SHIFT: begin
                    div_q <= div_q + 3'h1;
                    if (div_q == `SAR_CLK_HALF - 3'h1) begin
                        div_q  <= 3'h0;
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            // Sampled late in the bit: the answer bit only
                            // reaches the retimed pin after the rise.
                            if (bits_q >= `SAR_OP_BITS) begin
                                rx_q <= {rx_q[14:0], miso_s_q[1]};
                            end
                            tx_q   <= {tx_q[22:0], 1'b0};
                            bits_q <= bits_q + 5'h01;
                            if (bits_q == `SAR_FRAME_BITS - 5'h01) begin
                                st_q <= SAR_H_GAP;
                            end
                        end
                    end
                end
                SAR_H_GAP: begin
                    div_q <= div_q + 3'h1;
                    // Select stays high a while so the device sees a gap.
                    if (div_q == `SAR_CLK_HALF - 3'h1) begin
                        sel_n_q <= 1'b1;
                    end
                    if (div_q == `SAR_GAP_LAST) begin
                        st_q <= SAR_H_IDLE;
                    end
                end
                default: st_q <= SAR_H_IDLE;
            endcase
        end
    end

    // Answer fields are registered when the frame closes.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp_valid    <= 1'b0;
            rsp_word     <= 16'h0000;
            rsp_accepted <= 1'b0;
            rsp_done     <= 1'b0;
            rsp_result   <= 11'h000;
        end else begin
            rsp_valid <= 1'b0;
            if (st_q == SAR_H_GAP && div_q == `SAR_CLK_HALF - 3'h1) begin
                rsp_valid    <= 1'b1;
                rsp_word     <= rx_q;
                rsp_accepted <= ~rx_q[`SAR_ANS_REFUSE_BIT];
                rsp_done     <= rx_q[`SAR_ANS_DONE_BIT];
                // Result is only passed on with a completed flag.
                rsp_result   <= (rx_q[`SAR_ANS_DONE_BIT] &&
                                 !rx_q[`SAR_ANS_REFUSE_BIT]) ?
                    rx_q[`SAR_ANS_RES_HI:`SAR_ANS_RES_LO] : 11'h000;
            end
        end
    end

    assign link.sclk  = sclk_q;
    assign link.sel_n = sel_n_q;
    assign link.mosi  = tx_q[23];
endmodule

/* logic/sar_link_if.sv */
// Four-wire serial link between the host and the converter device.
`timescale 1ns/1ps
interface sar_link_if;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    modport device (
        input  sclk,
        input  sel_n,
        input  mosi,
        output miso_o,
        output miso_oe_n
    );
    modport host (
        output sclk,
        output sel_n,
        output mosi,
        input  miso_o,
        input  miso_oe_n
    );
endinterface

/* logic/sar_pkg.sv */
// Types shared by both ends of the converter readout link.
package sar_pkg;
    typedef logic [7:0]  sar_op_t;
    typedef logic [15:0] sar_word_t;
    typedef logic [10:0] sar_result_t;
    typedef enum logic [1:0] {
        SAR_CMD_RESULT  = 2'b00,
        SAR_CMD_STATUS  = 2'b01,
        SAR_CMD_CONVERT = 2'b10
    } sar_cmd_e;
endpackage

/* logic/sar_regs.svh */
// Command codes, answer field positions and timing counts of the readout link.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH
`define SAR_OP_RESULT_READ   8'h80
`define SAR_OP_STATUS_READ   8'h88
`define SAR_OP_CONV_MASK     8'hF3
`define SAR_OP_CONV_CTRL     8'h90
`define SAR_CONV_SEL_BIT     3
`define SAR_CONV_EN_BIT      2
`define SAR_ANS_REFUSE_BIT   15
`define SAR_ANS_OPC_BIT      14
`define SAR_ANS_DONE_BIT     13
`define SAR_ANS_BUSY_BIT     10
`define SAR_ANS_RES_HI       11
`define SAR_ANS_RES_LO       1
`define SAR_ANS_SEL_BIT      3
`define SAR_ANS_EN_BIT       2
`define SAR_OP_BITS          5'h08
`define SAR_FRAME_BITS       5'h18
`define SAR_CLK_HALF         3'h4
`define SAR_GAP_LAST         3'h7
`define SAR_CONV_TIME_US     115
`define SAR_CLK_MHZ          250
`define SAR_CONV_CYCLES      (`SAR_CONV_TIME_US * `SAR_CLK_MHZ + 1)
`define SAR_INIT_CYCLES      8'h40
`endif

/* tb/sar_link_monitor.sv */
// Concurrent checks on the serial link between host and device.
`timescale 1ns/1ps
module sar_link_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    logic [4:0] rise_q;
    logic       sclk_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
    end
    // Counts link clock rises inside the current frame only.
    always_ff @(posedge clk) begin
        if (!rstn || sel_n) begin
            rise_q <= 5'h00;
        end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 5'h01;
        end
    end
    sequence s_high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_gap;
        sel_n [*4];
    endsequence
    a_sclk_idle_low: assert property (sel_n |-> !sclk)
        else $error("link clock high outside a frame");
    a_sclk_high_four: assert property ($rose(sclk) |-> s_high_phase)
        else $error("link clock high phase not four cycles");
    a_frame_gap: assert property ($rose(sel_n) |-> s_gap)
        else $error("select gap shorter than four cycles");
    a_frame_bits: assert property ($rose(sel_n) |-> rise_q == 5'h18)
        else $error("frame did not hold 24 link clocks");
    a_quiet_opcode: assert property (!sel_n && rise_q < 5'h08 |-> miso_oe_n)
        else $error("device drove data during the opcode");
    a_drive_answer: assert property ($rose(sclk) && !sel_n && rise_q >= 5'h09
        |-> !miso_oe_n)
        else $error("device not driving during the answer");
    a_idle_release: assert property (s_gap |=> miso_oe_n)
        else $error("device still driving between frames");
    a_miso_steady: assert property (sclk && $past(sclk) && !miso_oe_n
        |-> $stable(miso_o))
        else $error("device data moved while link clock high");
    a_mosi_steady: assert property (sclk && !sel_n |-> $stable(mosi))
        else $error("host data moved while link clock high");
endmodule

/* tb/spi_adc_result_readout_tb_top.sv */
// Self-checking bench: host and device joined over the serial link.
`timescale 1ns/1ps
module spi_adc_result_readout_tb_top;
    import sar_pkg::*;
    logic        clk;
    logic        rstn;
    logic        req_valid;
    logic        req_ready;
    sar_op_t     req_op;
    logic        rsp_valid;
    sar_word_t   rsp_word;
    logic        rsp_accepted;
    logic        rsp_done;
    sar_result_t rsp_result;
    sar_result_t sample_in;
    sar_result_t held;
    logic        conv_start;
    logic        input_select;
    logic        converter_enable;
    logic [31:0] rnd;
    logic [23:0] mo_sh;
    logic [23:0] mi_sh;
    int          fails;
    int          n_tests;
    int          starts;
    sar_op_t     op_q[$];
    sar_word_t   exp_q[$];
    sar_word_t   msk_q[$];
    sar_link_if sar_link_if_inst ();
    sar_device sar_device_inst (.clk(clk), .rstn(rstn),
        .link(sar_link_if_inst), .sample_in(sample_in),
        .conv_start(conv_start), .input_select(input_select),
        .converter_enable(converter_enable));
    sar_host sar_host_inst (.clk(clk), .rstn(rstn), .link(sar_link_if_inst),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .rsp_valid(rsp_valid), .rsp_word(rsp_word),
        .rsp_accepted(rsp_accepted), .rsp_done(rsp_done),
        .rsp_result(rsp_result));
    sar_link_monitor sar_link_monitor_inst (.clk(clk), .rstn(rstn),
        .sclk(sar_link_if_inst.sclk), .sel_n(sar_link_if_inst.sel_n),
        .mosi(sar_link_if_inst.mosi), .miso_o(sar_link_if_inst.miso_o),
        .miso_oe_n(sar_link_if_inst.miso_oe_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic note(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // Wire words are checked too, so a slip on either end shows up.
    task automatic check_rsp(input sar_op_t op, input sar_word_t e, m);
        logic ok;
        ok = (rsp_word & m) === (e & m) && mo_sh[23:16] === op;
        ok = ok && (mi_sh[15:0] & m) === (e & m) && rsp_accepted === ~e[15];
        if (m[11:1] == 11'h7FF)
            ok = ok && rsp_result === e[11:1] && rsp_done === e[13];
        note(ok, "answer");
    endtask
    task automatic check_pin(input logic sel, input logic en, input int st);
        note(input_select === sel && converter_enable === en
            && starts == st, "pins");
    endtask
    task automatic send(input sar_op_t op, input sar_word_t e, m);
        int i;
        op_q.push_back(op);
        exp_q.push_back(e);
        msk_q.push_back(m);
        req_op = op;
        req_valid = 1'b1;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 req_valid = 1'b0;
        for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 400) begin
            note(1'b0, "timeout");
            end_of_test();
        end else
            $display("test op %h done", op);
    endtask
    always @(posedge sar_link_if_inst.sclk) begin
        mo_sh <= {mo_sh[22:0], sar_link_if_inst.mosi};
        mi_sh <= {mi_sh[22:0], sar_link_if_inst.miso_o};
    end
    always @(posedge clk) begin
        if (conv_start === 1'b1)
            starts++;
        if (rsp_valid === 1'b1 && exp_q.size() == 0)
            note(1'b0, "unexpected answer");
        else if (rsp_valid === 1'b1)
            check_rsp(op_q.pop_front(), exp_q.pop_front(), msk_q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_op = 8'h00;
        rnd = 32'h0000DA8F;
        fails = 0;
        n_tests = 0;
        starts = 0;
        sample_in = 11'h000;
        repeat (4) @(posedge clk);
        #1 rstn = 1'b1;
        check_pin(1'b0, 1'b0, 0);
        repeat (70) @(posedge clk);
        #1;
        send(8'h00, 16'hC000, 16'hC000);
        send(8'h80, 16'h0000, 16'h8001);
        rnd = xs(rnd);
        sample_in = rnd[10:0];
        send(8'h94, 16'h0004, 16'hA00C);
        check_pin(1'b0, 1'b1, 1);
        send(8'h80, 16'h0000, 16'hA001);
        send(8'h9C, 16'h8000, 16'hE000);
        check_pin(1'b0, 1'b1, 1);
        repeat (28751) @(posedge clk);
        #1;
        send(8'h80, {4'h2, sample_in, 1'b0}, 16'hAFFF);
        held = sample_in;
        rnd = xs(rnd);
        sample_in = rnd[10:0];
        send(8'h80, {4'h2, held, 1'b0}, 16'hAFFF);
        send(8'h9C, 16'h000C, 16'hA00C);
        check_pin(1'b1, 1'b1, 2);
        repeat (28751) @(posedge clk);
        #1;
        send(8'h80, {4'h2, sample_in, 1'b0}, 16'hAFFF);
        send(8'h90, 16'h0000, 16'h800C);
        check_pin(1'b0, 1'b0, 2);
        send(8'h88, 16'h2000, 16'hA00C);
        repeat (2) @(posedge clk);
        note(exp_q.size() == 0, "answers missing");
        end_of_test();
    end
endmodule
